// ---- design/odc_bank.v ----
// configuration bank for the top and bottom output channels
`default_nettype none
`include "odc_defines.vh"
module odc_bank (
    input  wire        REF_CLK_IN,
    input  wire        RST_N_IN,
    input  wire        WR_EN_IN,
    input  wire [7:0]  ADDR_IN,
    input  wire [7:0]  WDATA_IN,
    output reg  [7:0]  RDATA_OUT,
    input  wire        TOP_TRUE_CLOCK_IN,
    input  wire        TOP_COMPLEMENT_CLOCK_IN,
    input  wire        BOT_TRUE_CLOCK_IN,
    input  wire        BOT_COMPLEMENT_CLOCK_IN,
    output wire        TOP_POSITIVE_PIN_OUT,
    output wire        TOP_NEGATIVE_PIN_OUT,
    output wire        BOT_POSITIVE_PIN_OUT,
    output wire        BOT_NEGATIVE_PIN_OUT,
    output reg  [29:0] TOP_OUTPUT_DIVIDER_VALUE_OUT,
    output reg  [23:0] BOT_OUTPUT_DIVIDER_VALUE_OUT,
    output reg  [5:0]  TOP_COARSE_DELAY_OUT,
    output reg  [2:0]  TOP_FINE_DELAY_OUT,
    output reg  [1:0]  TOP_SUPPLY_LEVEL_CODE_OUT,
    output reg  [2:0]  TOP_DRIVER_STANDARD_OUT,
    output reg  [3:0]  TOP_PIN_MODE_OUT,
    output reg  [2:0]  TOP_DRIVE_STRENGTH_OUT,
    output reg  [2:0]  BOT_DRIVE_STRENGTH_OUT,
    output reg         TOP_CONFIG_VALID_OUT
);
    wire [7:0] top_div_high; // divider 19:16 and 29:28 bits via drv std
    wire [7:0] top_div_mid;  // divider 15:8
    wire [7:0] top_div_low;  // divider 7:0
    wire [7:0] top_phase;    // phase select and strength
    wire [7:0] top_delay;    // coarse and fine delay
    wire [7:0] top_drv_std;  // standard, supply? see layout below
    wire [7:0] top_pin_mode; // pin mode code
    wire [7:0] bot_div_high; // divider 23:16
    wire [7:0] bot_div_mid;  // divider 15:8
    wire [7:0] bot_div_low;  // divider 7:0
    wire [7:0] bot_phase;    // phase select and strength
    wire [10:0] hits;        // per-register address match
    // top channel registers
    odc_field_reg #(.OFFSET(`ODC_OFS_TOP_DIV_HIGH), .MASK(`ODC_DIV_HIGH_MASK)) u_tdh (.clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN), .wr_en_in(WR_EN_IN), .addr_in(ADDR_IN), .wdata_in(WDATA_IN),
        .hit_out(hits[0]), .value_out(top_div_high));
    odc_field_reg #(.OFFSET(`ODC_OFS_TOP_DIV_MID)) u_tdm (.clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN), .wr_en_in(WR_EN_IN), .addr_in(ADDR_IN), .wdata_in(WDATA_IN),
        .hit_out(hits[1]), .value_out(top_div_mid));
    odc_field_reg #(.OFFSET(`ODC_OFS_TOP_DIV_LOW)) u_tdl (.clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN), .wr_en_in(WR_EN_IN), .addr_in(ADDR_IN), .wdata_in(WDATA_IN),
        .hit_out(hits[2]), .value_out(top_div_low));
    odc_field_reg #(.OFFSET(`ODC_OFS_TOP_PHASE), .MASK(`ODC_PHASE_MASK)) u_tph (.clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN), .wr_en_in(WR_EN_IN), .addr_in(ADDR_IN), .wdata_in(WDATA_IN),
        .hit_out(hits[3]), .value_out(top_phase));
    odc_field_reg #(.OFFSET(`ODC_OFS_TOP_DELAY)) u_tdy (.clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN), .wr_en_in(WR_EN_IN), .addr_in(ADDR_IN), .wdata_in(WDATA_IN),
        .hit_out(hits[4]), .value_out(top_delay));
    odc_field_reg #(.OFFSET(`ODC_OFS_TOP_DRV_STD), .MASK(`ODC_DRV_STD_MASK)) u_tds (.clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN), .wr_en_in(WR_EN_IN), .addr_in(ADDR_IN), .wdata_in(WDATA_IN),
        .hit_out(hits[5]), .value_out(top_drv_std));
    odc_field_reg #(.OFFSET(`ODC_OFS_TOP_PIN_MODE), .MASK(`ODC_PIN_MODE_MASK)) u_tpm (.clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN), .wr_en_in(WR_EN_IN), .addr_in(ADDR_IN), .wdata_in(WDATA_IN),
        .hit_out(hits[6]), .value_out(top_pin_mode));
    // bottom channel registers, full bytes except the phase register
    odc_field_reg #(.OFFSET(`ODC_OFS_BOT_DIV_HIGH)) u_bdh (.clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN), .wr_en_in(WR_EN_IN), .addr_in(ADDR_IN), .wdata_in(WDATA_IN),
        .hit_out(hits[7]), .value_out(bot_div_high));
    odc_field_reg #(.OFFSET(`ODC_OFS_BOT_DIV_MID)) u_bdm (.clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN), .wr_en_in(WR_EN_IN), .addr_in(ADDR_IN), .wdata_in(WDATA_IN),
        .hit_out(hits[8]), .value_out(bot_div_mid));
    odc_field_reg #(.OFFSET(`ODC_OFS_BOT_DIV_LOW)) u_bdl (.clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN), .wr_en_in(WR_EN_IN), .addr_in(ADDR_IN), .wdata_in(WDATA_IN),
        .hit_out(hits[9]), .value_out(bot_div_low));
    odc_field_reg #(.OFFSET(`ODC_OFS_BOT_PHASE), .MASK(`ODC_PHASE_MASK)) u_bph (.clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN), .wr_en_in(WR_EN_IN), .addr_in(ADDR_IN), .wdata_in(WDATA_IN),
        .hit_out(hits[10]), .value_out(bot_phase));

    // read mux; unmapped offsets read zero
    always @* begin
        if (hits[0]) begin
            RDATA_OUT = top_div_high;
        end else if (hits[1]) begin
            RDATA_OUT = top_div_mid;
        end else if (hits[2]) begin
            RDATA_OUT = top_div_low;
        end else if (hits[3]) begin
            RDATA_OUT = top_phase;
        end else if (hits[4]) begin
            RDATA_OUT = top_delay;
        end else if (hits[5]) begin
            RDATA_OUT = top_drv_std;
        end else if (hits[6]) begin
            RDATA_OUT = top_pin_mode;
        end else if (hits[7]) begin
            RDATA_OUT = bot_div_high;
        end else if (hits[8]) begin
            RDATA_OUT = bot_div_mid;
        end else if (hits[9]) begin
            RDATA_OUT = bot_div_low;
        end else if (hits[10]) begin
            RDATA_OUT = bot_phase;
        end else begin
            RDATA_OUT = `ODC_RESET_VALUE;
        end
    end

    // channel decode registered from the bank
    always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            TOP_OUTPUT_DIVIDER_VALUE_OUT <= 30'h0;
            BOT_OUTPUT_DIVIDER_VALUE_OUT <= 24'h0;
            TOP_COARSE_DELAY_OUT         <= 6'h0;
            TOP_FINE_DELAY_OUT           <= 3'h0;
            TOP_SUPPLY_LEVEL_CODE_OUT    <= 2'h0;
            TOP_DRIVER_STANDARD_OUT      <= 3'h0;
            TOP_PIN_MODE_OUT             <= 4'h0;
            TOP_DRIVE_STRENGTH_OUT       <= 3'h0;
            BOT_DRIVE_STRENGTH_OUT       <= 3'h0;
            TOP_CONFIG_VALID_OUT         <= 1'b0;
        end else begin
            // 29:28 from drv byte 7:6, 27:20 zero, 19:16 from high byte 3:0, rest bytes
            TOP_OUTPUT_DIVIDER_VALUE_OUT <= {top_drv_std[7:6], 8'h00, top_div_high[3:0],
                                             top_div_mid, top_div_low};
            BOT_OUTPUT_DIVIDER_VALUE_OUT <= {bot_div_high, bot_div_mid, bot_div_low};
            TOP_COARSE_DELAY_OUT         <= top_delay[5:0];
            // bit 4 of the standard byte extends fine delay to three bits
            TOP_FINE_DELAY_OUT           <= {top_drv_std[4], top_delay[7:6]};
            TOP_SUPPLY_LEVEL_CODE_OUT    <= top_drv_std[4:3];
            TOP_DRIVER_STANDARD_OUT      <= top_drv_std[2:0];
            TOP_PIN_MODE_OUT             <= top_pin_mode[3:0];
            TOP_DRIVE_STRENGTH_OUT       <= top_phase[2:0]; // recommended 111
            BOT_DRIVE_STRENGTH_OUT       <= bot_phase[2:0];
            // flags codes outside the documented sets
            TOP_CONFIG_VALID_OUT <= (top_drv_std[2:0] <= `ODC_STD_MAX) &&
                                    (top_drv_std[4:3] <= `ODC_SUPPLY_MAX) &&
                                    ({top_drv_std[4], top_delay[7:6]} <= `ODC_FINE3_MAX);
        end
    end

    // pin routing per channel
    odc_clock_router u_top_route (
        .phase_sel_in        (top_phase[7:6]),
        .true_clock_in       (TOP_TRUE_CLOCK_IN),
        .complement_clock_in (TOP_COMPLEMENT_CLOCK_IN),
        .positive_pin_out    (TOP_POSITIVE_PIN_OUT),
        .negative_pin_out    (TOP_NEGATIVE_PIN_OUT)
    );
    odc_clock_router u_bot_route (
        .phase_sel_in        (bot_phase[7:6]),
        .true_clock_in       (BOT_TRUE_CLOCK_IN),
        .complement_clock_in (BOT_COMPLEMENT_CLOCK_IN),
        .positive_pin_out    (BOT_POSITIVE_PIN_OUT),
        .negative_pin_out    (BOT_NEGATIVE_PIN_OUT)
    );
endmodule
`default_nettype wire

// ---- design/odc_clock_router.v ----
// routes true and complement clocks onto the two single-ended drivers
`default_nettype none
`include "odc_defines.vh"
module odc_clock_router (
    input  wire [1:0] phase_sel_in,
    input  wire       true_clock_in,
    input  wire       complement_clock_in,
    output reg        positive_pin_out,
    output reg        negative_pin_out
);
    // 00 differential, 01 true on both, 1x complement on both
    always @* begin
        if (phase_sel_in == `ODC_PHASE_DIFF) begin
            positive_pin_out = true_clock_in;
            negative_pin_out = complement_clock_in;
        end else if (phase_sel_in == `ODC_PHASE_TRUE_BOTH) begin
            positive_pin_out = true_clock_in;
            negative_pin_out = true_clock_in;
        end else begin
            positive_pin_out = complement_clock_in;
            negative_pin_out = complement_clock_in;
        end
    end
endmodule
`default_nettype wire

// ---- design/odc_defines.vh ----
// constants and field layout of the output divider configuration bank
`ifndef ODC_DEFINES_VH
`define ODC_DEFINES_VH
`define ODC_OFS_TOP_DIV_HIGH   8'h50
`define ODC_OFS_TOP_DIV_MID    8'h51
`define ODC_OFS_TOP_DIV_LOW    8'h52
`define ODC_OFS_TOP_PHASE      8'h53
`define ODC_OFS_TOP_DELAY      8'h54
`define ODC_OFS_TOP_DRV_STD    8'h55
`define ODC_OFS_TOP_PIN_MODE   8'h57
`define ODC_OFS_BOT_DIV_HIGH   8'h60
`define ODC_OFS_BOT_DIV_MID    8'h61
`define ODC_OFS_BOT_DIV_LOW    8'h62
`define ODC_OFS_BOT_PHASE      8'h63
`define ODC_RESET_VALUE        8'h00
`define ODC_DIV_HIGH_MASK      8'h0f
`define ODC_PHASE_MASK         8'hc7
`define ODC_DRV_STD_MASK       8'hdf
`define ODC_PIN_MODE_MASK      8'h0f
`define ODC_FINE_STEP_PS       30
`define ODC_FINE3_MAX          3'h4
`define ODC_PHASE_DIFF         2'h0
`define ODC_PHASE_TRUE_BOTH    2'h1
`define ODC_STD_MAX            3'h5
`define ODC_SUPPLY_MAX         2'h2
`endif

// ---- design/odc_field_reg.v ----
// one byte-wide configuration register with a write mask
`default_nettype none
module odc_field_reg #(
    parameter [7:0] OFFSET = 8'h00,
    parameter [7:0] MASK   = 8'hff
) (
    input  wire       clk_in,
    input  wire       rst_n_in,
    input  wire       wr_en_in,
    input  wire [7:0] addr_in,
    input  wire [7:0] wdata_in,
    output wire       hit_out,
    output reg  [7:0] value_out
);
    assign hit_out = (addr_in == OFFSET);
    // masked store; spare bits stay zero
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            value_out <= 8'h00;
        end else if (wr_en_in && hit_out) begin
            value_out <= wdata_in & MASK;
        end
    end
endmodule
`default_nettype wire

// ---- tb/odc_bank_chk.sv ----
// port checker of the output divider configuration bank
`default_nettype none
module odc_bank_chk (
    input wire logic        REF_CLK_IN,
    input wire logic        RST_N_IN,
    input wire logic        WR_EN_IN,
    input wire logic [7:0]  ADDR_IN,
    input wire logic [7:0]  WDATA_IN,
    input wire logic [7:0]  RDATA_OUT,
    input wire logic        TOP_TRUE_CLOCK_IN,
    input wire logic        TOP_COMPLEMENT_CLOCK_IN,
    input wire logic        TOP_POSITIVE_PIN_OUT,
    input wire logic        TOP_NEGATIVE_PIN_OUT,
    input wire logic [29:0] TOP_OUTPUT_DIVIDER_VALUE_OUT,
    input wire logic [23:0] BOT_OUTPUT_DIVIDER_VALUE_OUT,
    input wire logic [5:0]  TOP_COARSE_DELAY_OUT,
    input wire logic        TOP_CONFIG_VALID_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // decoded fields follow a write two edges on
    div_low_a: assert property (WR_EN_IN && ADDR_IN == 8'h52 |-> ##2
        TOP_OUTPUT_DIVIDER_VALUE_OUT[7:0] == $past(WDATA_IN, 2)) else $error("top divider low byte wrong");
    div_upper_a: assert property (WR_EN_IN && ADDR_IN == 8'h55 |-> ##2
        TOP_OUTPUT_DIVIDER_VALUE_OUT[29:28] == $past(WDATA_IN[7:6], 2)) else $error("top divider upper bits wrong");
    bot_high_a: assert property (WR_EN_IN && ADDR_IN == 8'h60 |-> ##2
        BOT_OUTPUT_DIVIDER_VALUE_OUT[23:16] == $past(WDATA_IN, 2)) else $error("bottom divider high byte wrong");
    coarse_delay_a: assert property (WR_EN_IN && ADDR_IN == 8'h54 |-> ##2
        TOP_COARSE_DELAY_OUT == $past(WDATA_IN[5:0], 2)) else $error("coarse delay wrong");
    // spare bit 5 of the standard register reads back as zero
    std_readback_a: assert property (WR_EN_IN && ADDR_IN == 8'h55 ##1 ADDR_IN == 8'h55 |->
        RDATA_OUT == ($past(WDATA_IN) & 8'hdf)) else $error("standard register readback wrong");
    unmapped_read_a: assert property (ADDR_IN == 8'h56 |-> RDATA_OUT == 8'h00)
        else $error("unmapped offset reads nonzero");
    phase_diff_a: assert property (ADDR_IN == 8'h53 && RDATA_OUT[7:6] == 2'h0 |->
        TOP_POSITIVE_PIN_OUT == TOP_TRUE_CLOCK_IN && TOP_NEGATIVE_PIN_OUT == TOP_COMPLEMENT_CLOCK_IN)
        else $error("phase 00 routing wrong");
    phase_true_a: assert property (ADDR_IN == 8'h53 && RDATA_OUT[7:6] == 2'h1 |->
        TOP_POSITIVE_PIN_OUT == TOP_TRUE_CLOCK_IN && TOP_NEGATIVE_PIN_OUT == TOP_TRUE_CLOCK_IN)
        else $error("phase 01 routing wrong");
    valid_start_a: assert property ($rose(RST_N_IN) |-> !TOP_CONFIG_VALID_OUT ##1 TOP_CONFIG_VALID_OUT)
        else $error("valid flag timing after reset wrong");
endmodule
bind odc_bank odc_bank_chk u_chk (.REF_CLK_IN(REF_CLK_IN), .RST_N_IN(RST_N_IN), .WR_EN_IN(WR_EN_IN),
    .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .RDATA_OUT(RDATA_OUT), .TOP_TRUE_CLOCK_IN(TOP_TRUE_CLOCK_IN),
    .TOP_COMPLEMENT_CLOCK_IN(TOP_COMPLEMENT_CLOCK_IN), .TOP_POSITIVE_PIN_OUT(TOP_POSITIVE_PIN_OUT),
    .TOP_NEGATIVE_PIN_OUT(TOP_NEGATIVE_PIN_OUT), .TOP_OUTPUT_DIVIDER_VALUE_OUT(TOP_OUTPUT_DIVIDER_VALUE_OUT),
    .BOT_OUTPUT_DIVIDER_VALUE_OUT(BOT_OUTPUT_DIVIDER_VALUE_OUT), .TOP_COARSE_DELAY_OUT(TOP_COARSE_DELAY_OUT),
    .TOP_CONFIG_VALID_OUT(TOP_CONFIG_VALID_OUT));
`default_nettype wire

// ---- tb/odc_bank_tb.sv ----
// self-checking bench of the output divider configuration bank
`default_nettype none
module odc_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, wr = 0;
    logic [7:0] addr = 8'h00, wd = 8'h00;
    logic [3:0] ck = 4'h0; // top true, top complement, bottom true, bottom complement
    wire [7:0] rd;
    wire [3:0] pin;
    wire [29:0] tdiv;
    wire [23:0] bdiv;
    wire [5:0] cdly;
    wire [2:0] fdly, dstd, tstr, bstr;
    wire [1:0] sup;
    wire [3:0] pm;
    wire vld;
    int n_tests = 0, n_mismatch = 0, cyc = 0;
    // rows: offset, write data, expected readback
    logic [23:0] rows [13] = '{24'h50ff0f, 24'h51aaaa, 24'h525555, 24'h53ffc7, 24'h54c5c5, 24'h55ffdf,
        24'h57ff0f, 24'h601212, 24'h613434, 24'h625656, 24'h637b43, 24'h56ff00, 24'h58ff00};
    logic [3:0] pmc [6] = '{4'h0, 4'h2, 4'h1, 4'h4, 4'h8, 4'hc};
    odc_bank DUT (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .WR_EN_IN(wr), .ADDR_IN(addr), .WDATA_IN(wd),
        .RDATA_OUT(rd), .TOP_TRUE_CLOCK_IN(ck[3]), .TOP_COMPLEMENT_CLOCK_IN(ck[2]),
        .BOT_TRUE_CLOCK_IN(ck[1]), .BOT_COMPLEMENT_CLOCK_IN(ck[0]), .TOP_POSITIVE_PIN_OUT(pin[3]),
        .TOP_NEGATIVE_PIN_OUT(pin[2]), .BOT_POSITIVE_PIN_OUT(pin[1]), .BOT_NEGATIVE_PIN_OUT(pin[0]),
        .TOP_OUTPUT_DIVIDER_VALUE_OUT(tdiv), .BOT_OUTPUT_DIVIDER_VALUE_OUT(bdiv), .TOP_COARSE_DELAY_OUT(cdly),
        .TOP_FINE_DELAY_OUT(fdly), .TOP_SUPPLY_LEVEL_CODE_OUT(sup), .TOP_DRIVER_STANDARD_OUT(dstd),
        .TOP_PIN_MODE_OUT(pm), .TOP_DRIVE_STRENGTH_OUT(tstr), .BOT_DRIVE_STRENGTH_OUT(bstr),
        .TOP_CONFIG_VALID_OUT(vld));
    always #5 clk = ~clk;
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // strobe stays up across back-to-back writes; caller drops it
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        wr = 1;
        addr = a;
        wd = d;
        @(posedge clk);
        #1;
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
        addr = a;
        @(posedge clk);
        #1 chk(nm, e, rd);
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            n_mismatch++;
            test_done();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        #1 rst_n = 1;
        foreach (rows[i]) rd_chk("reset value", rows[i][23:16], 8'h00);
        foreach (rows[i]) wr_reg(rows[i][23:16], rows[i][15:8]);
        wr = 0;
        foreach (rows[i]) rd_chk("readback", rows[i][23:16], rows[i][7:0]);
        $display("register table test done");
        chk("top divider", 32'h300faa55, tdiv);
        chk("bottom divider", 32'h123456, bdiv);
        chk("strengths", 32'h73, {tstr, 1'b0, bstr});
        $display("divider test done");
        for (int i = 0; i < 6; i++) begin
            wr_reg(8'h54, {2'(i + 2), 6'(63 - i)});
            wr_reg(8'h57, pmc[i]);
            wr_reg(8'h55, {3'h0, 2'(i % 3), 3'(i)});
            wr = 0;
            rd_chk("standard readback", 8'h55, {3'h0, 2'(i % 3), 3'(i)});
            chk("driver standard", i, dstd);
            chk("supply level", i % 3, sup);
            chk("coarse delay", 63 - i, cdly);
            chk("fine delay", {i % 3 == 2, 2'(i + 2)}, fdly);
            chk("pin mode", pmc[i], pm);
            chk("config valid", i != 5, vld);
        end
        $display("encoding test done");
        for (int p = 0; p < 4; p++) begin
            wr_reg(8'h63, {2'(p), 6'h03});
            wr_reg(8'h53, {2'(p), 6'h07});
            wr = 0;
            for (int k = 0; k < 2; k++) begin
                ck = k ? 4'b0101 : 4'b1010;
                @(posedge clk);
                #1 chk("pins", {p[1] ? ck[2] : ck[3], p == 1 ? ck[3] : ck[2],
                    p[1] ? ck[0] : ck[1], p == 1 ? ck[1] : ck[0]}, pin);
            end
        end
        $display("phase test done");
        rst_n = 0;
        ck = 4'b1010;
        @(posedge clk);
        #1 chk("divider in reset", 0, tdiv);
        chk("pins in reset", 4'b1010, pin);
        chk("valid in reset", 0, vld);
        rst_n = 1;
        rd_chk("phase after reset", 8'h53, 8'h00);
        chk("valid after reset", 1, vld);
        $display("mid-run reset test done");
        test_done();
    end
endmodule
`default_nettype wire
